// ---- fixed_point_requantizer_tb_top.sv ----
// Self-checking testbench of the fixed-point requantizer.
`timescale 1ns/1ps
module fixed_point_requantizer_tb_top;
  localparam int LAT = 2;
  localparam logic [31:0] VEC [8] = '{32'h0000_0180, 32'hffff_fe80, 32'h0000_017f,
    32'hffff_fe81, 32'h007f_ff80, 32'h8000_0000, 32'hff80_0000, 32'h1234_5678};
  logic aclk = 1'b0;
  logic aresetn, slow, mon_en;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic in_valid, out_valid, out_ovf;
  logic [31:0] in_data;
  logic [15:0] out_data;
  logic [16:0] exp_q[$];
  logic [16:0] mon_e;
  int n_fail = 0;
  int n_tests = 0;
  always #5 aclk = ~aclk;
  fpr_top #(.LATENCY(LAT)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .in_valid(in_valid),
    .in_data(in_data), .out_valid(out_valid), .out_data(out_data), .out_ovf(out_ovf));
  fpr_src i_src (.aclk(aclk), .aresetn(aresetn), .slow(slow), .in_valid(in_valid),
    .in_data(in_data));
  ////////////////////////////////////////
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Ties go away from zero, so negative values round on their magnitude.
  function automatic logic [16:0] model(input logic [31:0] x, input logic rnd,
                                        input logic [1:0] md);
    longint v;
    longint t;
    logic o;
    v = longint'(signed'(x));
    if (rnd && v < 0) t = -((-v + 128) >>> 8);
    else if (rnd) t = (v + 128) >>> 8;
    else t = v >>> 8;
    o = (t > 32767) || (t < -32768);
    if (o && md == fpr_pkg::FPR_OVF_SAT) t = (t > 0) ? 32767 : -32768;
    return {o, t[15:0]};
  endfunction : model
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (k == 50) begin n_fail++; end_sim(); end
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k == 50) begin n_fail++; end_sim(); end
  endtask : axi_rd
  task automatic drain();
    int k;
    for (k = 0; k < 300 && (i_src.busy() != 0 || exp_q.size() != 0); k++) @(posedge aclk);
    if (k == 300) begin n_fail++; end_sim(); end
  endtask : drain
  ////////////////////////////////////////
  always @(posedge aclk) begin
    if (mon_en && aresetn && out_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("extra sample", 32'h1, 32'h0);
      else begin
        mon_e = exp_q.pop_front();
        chk("data", 32'(out_data), 32'(mon_e[15:0]));
        chk("out_ovf", {31'h0, out_ovf}, {31'h0, mon_e[16]});
      end
    end
  end
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(8'h00, d, r);
    chk("ctrl", d, 32'h1);
    axi_wr(8'h10, 32'h0, 2'h0);
    axi_rd(8'h10, d, r);
    chk("config", d, 32'h8008_0010);
    axi_rd(8'h14, d, r);
    chk("unmapped", {r, d[29:0]}, 32'h8000_0000);
    axi_wr(8'h14, 32'h1, 2'h2);
  endtask : t_regs
  task automatic t_quant();
    logic [31:0] d;
    logic [1:0] r;
    logic [16:0] e;
    for (int m = 0; m < 3; m++) begin
      for (int q = 0; q < 2; q++) begin
        slow <= (m == 1);
        axi_wr(8'h00, {28'h0, 2'(m), 1'(q), 1'b1}, 2'h0);
        axi_wr(8'h04, 32'h1, 2'h0);
        foreach (VEC[i]) begin
          i_src.push(VEC[i]);
          e = model(VEC[i], 1'(q), 2'(m));
          exp_q.push_back(e);
        end
        drain();
        axi_rd(8'h04, d, r);
        chk("status", d, 32'h1);
        axi_rd(8'h0c, d, r);
        chk("count", d, 32'((m * 2 + q + 1) * 8));
      end
    end
  endtask : t_quant
  task automatic t_latency();
    int n;
    int k;
    slow <= 1'b0;
    axi_wr(8'h00, 32'h1, 2'h0);
    i_src.push(32'h0002_0000);
    exp_q.push_back(model(32'h0002_0000, 1'b0, 2'h0));
    // Count from the cycle in which the sample stands at the input, not from the push.
    for (k = 0; k < 20; k++) begin
      #1;
      if (in_valid === 1'b1) break;
      @(posedge aclk);
    end
    for (n = 1; n < 20; n++) begin
      @(posedge aclk);
      #1;
      if (out_valid === 1'b1) break;
    end
    chk("latency", 32'(n), 32'(LAT));
    drain();
  endtask : t_latency
  // The stream is kept full so the last stage is valid when the enable drops.
  task automatic t_hold();
    logic [31:0] d;
    logic [1:0] r;
    mon_en = 1'b0;
    repeat (30) i_src.push(32'h0003_0000);
    repeat (8) @(posedge aclk);
    axi_wr(8'h00, 32'h0, 2'h0);
    repeat (30) i_src.push(32'h0005_0000);
    repeat (50) @(posedge aclk);
    chk("hold valid", {31'h0, out_valid}, 32'h1);
    chk("hold data", {16'h0, out_data}, 32'h0300);
    axi_rd(8'h08, d, r);
    chk("result", d, 32'h0300);
    axi_wr(8'h00, 32'h11, 2'h0);
    repeat (3) @(posedge aclk);
    chk("clear valid", {31'h0, out_valid}, 32'h0);
    axi_rd(8'h00, d, r);
    chk("ctrl after clear", d, 32'h1);
    axi_rd(8'h0c, d, r);
    chk("count after clear", d, 32'h0);
    axi_wr(8'h00, 32'h1, 2'h0);
    mon_en = 1'b1;
  endtask : t_hold
  ////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    slow = 1'b0;
    mon_en = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_quant();
    t_latency();
    t_hold();
    end_sim();
  end
  initial begin
    #900000;
    n_fail++;
    end_sim();
  end
endmodule : fixed_point_requantizer_tb_top

// ---- fpr_map.svh ----
// Register map, field positions and reset values of the fixed-point requantizer.
`ifndef FPR_MAP_SVH
`define FPR_MAP_SVH

`define FPR_ADDR_W 8
`define FPR_MAX_WIDTH 4096

`define FPR_CTRL_OFS 8'h00
`define FPR_STATUS_OFS 8'h04
`define FPR_RESULT_OFS 8'h08
`define FPR_COUNT_OFS 8'h0c
`define FPR_CONFIG_OFS 8'h10

`define FPR_CTRL_EN_BIT 0
`define FPR_CTRL_RND_BIT 1
`define FPR_CTRL_OVF_LSB 2
`define FPR_CTRL_OVF_MSB 3
`define FPR_CTRL_CLR_BIT 4
`define FPR_CTRL_RST 4'h1

`define FPR_STAT_OVF_BIT 0

`define FPR_CFG_W_MSB 15
`define FPR_CFG_FRAC_LSB 16
`define FPR_CFG_FRAC_MSB 28
`define FPR_CFG_FULL_BIT 30
`define FPR_CFG_SIGN_BIT 31

`define FPR_RESP_OKAY 2'h0
`define FPR_RESP_SLVERR 2'h2

`endif

// ---- fpr_pkg.sv ----
// Types shared by the fixed-point requantizer modules.
package fpr_pkg;

  typedef enum logic [1:0] {
    FPR_OVF_WRAP = 2'h0,
    FPR_OVF_SAT = 2'h1,
    FPR_OVF_FLAG = 2'h2
  } fpr_ovf_type;

  typedef enum logic {
    FPR_Q_TRUNC = 1'h0,
    FPR_Q_ROUND = 1'h1
  } fpr_quant_type;

endpackage : fpr_pkg

// ---- fpr_requant.sv ----
// Combinational requantizer: drops or rounds fraction bits, then handles overflow.
`timescale 1ns/1ps
`include "fpr_map.svh"
module fpr_requant #(
  parameter int IN_W = 32,
  parameter int IN_FRAC = 16,
  parameter int IN_SIGNED = 1,
  parameter int OUT_W = 16,
  parameter int OUT_FRAC = 8,
  parameter int OUT_SIGNED = 1
) (
  // Full-precision operand.
  input wire logic [IN_W-1:0] din,
  // Mode selects.
  input wire logic round_sel,
  input wire logic sat_sel,
  // Result and views of the wide intermediate value.
  output logic [OUT_W-1:0] dout,
  output logic ovf,
  output logic [IN_W+OUT_W+1:0] q_trunc,
  output logic [IN_W+OUT_W+1:0] q_full
);
  // Two spare bits above any shifted operand keep the rounding sum exact.
  localparam int WW = IN_W + OUT_W + 2;
  localparam int SH = IN_FRAC - OUT_FRAC;
  localparam logic signed [WW-1:0] MAX_V = (WW'(1) << (OUT_W - OUT_SIGNED)) - WW'(1);
  localparam logic signed [WW-1:0] MIN_V = (OUT_SIGNED != 0) ? -(WW'(1) << (OUT_W - 1)) : '0;

  logic signed [WW-1:0] ext;
  logic signed [WW-1:0] q_t;
  logic signed [WW-1:0] q_r;

  //////////////////////////////////////////////////////////////////////////////
  if (OUT_W < 1 || OUT_W > `FPR_MAX_WIDTH || IN_W < 1 || IN_W > `FPR_MAX_WIDTH) begin : g_bad_w
    $error("Word width outside the supported range."); // RULE2
  end
  if (OUT_FRAC < 0 || OUT_FRAC > OUT_W || IN_FRAC < 0 || IN_FRAC > IN_W) begin : g_bad_pt
    $error("Binary point outside the word."); // RULE3
  end

  always_comb begin
    if (IN_SIGNED != 0) begin
      ext = WW'($signed(din));
    end else begin
      ext = WW'(din);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fraction bits are settled before the range test, so a rounding carry is seen.
  if (SH > 0) begin : g_drop
    localparam logic signed [WW-1:0] HALF = WW'(1) << (SH - 1);
    always_comb begin
      q_t = ext >>> SH; // RULE10
      if (round_sel) begin
        // Negative values get half minus one so ties still move away from zero.
        q_r = (ext + (ext[WW-1] ? HALF - WW'(1) : HALF)) >>> SH; // RULE9 RULE14
      end else begin
        q_r = q_t;
      end
    end
  end else begin : g_keep
    always_comb begin
      q_t = ext <<< (-SH);
      q_r = q_t;
    end
  end

  always_comb begin
    ovf = (q_r > MAX_V) || (q_r < MIN_V); // RULE14
    if (sat_sel && q_r > MAX_V) begin
      dout = MAX_V[OUT_W-1:0]; // RULE6
    end else if (sat_sel && q_r < MIN_V) begin
      dout = MIN_V[OUT_W-1:0]; // RULE6
    end else begin
      dout = q_r[OUT_W-1:0]; // RULE7 RULE8
    end
  end

  assign q_trunc = q_t;
  assign q_full = q_r;

endmodule : fpr_requant

// ---- fpr_src.sv ----
// Upstream datapath model that feeds full-precision samples to the requantizer.
`timescale 1ns/1ps
module fpr_src #(
  parameter int W = 32
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Pace select and sample output.
  input wire logic slow,
  output logic in_valid,
  output logic [W-1:0] in_data
);
  logic [W-1:0] q[$];
  logic gap;
  function automatic int busy();
    return q.size();
  endfunction : busy
  task automatic push(input logic [W-1:0] d);
    q.push_back(d);
  endtask : push
  initial begin
    in_valid = 1'b0;
    in_data = '0;
    gap = 1'b0;
  end
  ////////////////////////////////////////
  // Idle cycles invert the word on the bus at every edge, so stale data never looks valid.
  always @(posedge aclk) begin
    gap <= slow && !gap;
    if (!aresetn || q.size() == 0 || (slow && gap)) begin
      in_valid <= 1'b0;
      in_data <= ~in_data;
    end else begin
      in_valid <= 1'b1;
      in_data <= q.pop_front();
    end
  end
endmodule : fpr_src

// ---- fpr_top.sv ----
// Fixed-point requantizer with output delay line and AXI4-Lite control registers.
//
// Contract
// [RULE1] Output word is unsigned or two's complement, chosen by a build parameter.
// [RULE2] Output width may be anything up to 4096 bits.
// [RULE3] Binary point lies from zero to the width; other values fail elaboration.
// [RULE4] Full precision keeps the exact result, with no rounding or overflow handling.
// [RULE5] Rounding and overflow handling act only with a narrower user format.
// [RULE6] Saturate clamps above range to largest code, below to most negative.
// [RULE7] Wrap keeps only the low bits that fit the output width.
// [RULE8] Flag-as-error mode builds exactly the wrap hardware.
// [RULE9] Round goes to nearest value, ties to the larger magnitude.
// [RULE10] Truncate drops bits below the output LSB with no increment.
// [RULE11] Latency is a register delay line on the output.
// [RULE12] Synchronous clear restores the initial state and beats the enable; the code leaves the sticky overflow flag as it is.
// [RULE13] With enable low the block holds its state.
// [RULE14] Quantize first, then handle overflow, so rounding carries are caught.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "fpr_map.svh"
module fpr_top #(
  parameter int IN_W = 32,
  parameter int IN_FRAC = 16,
  parameter int IN_SIGNED = 1,
  parameter int OUT_W = 16,
  parameter int OUT_FRAC = 8,
  parameter int OUT_SIGNED = 1,
  parameter int FULL_PREC = 0,
  parameter int LATENCY = 2
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [`FPR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [`FPR_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Full-precision samples from the datapath.
  input wire logic in_valid,
  input wire logic [IN_W-1:0] in_data,
  // Requantized samples.
  output logic out_valid,
  output logic [OUT_W-1:0] out_data,
  output logic out_ovf
);
  localparam int WW = IN_W + OUT_W + 2;
  localparam int RW = (OUT_W < 32) ? OUT_W : 32;
  localparam logic [OUT_W-1:0] SAT_HI = (OUT_SIGNED != 0) ? ~(OUT_W'(1) << (OUT_W - 1)) : '1;
  localparam logic [OUT_W-1:0] SAT_LO = (OUT_SIGNED != 0) ? (OUT_W'(1) << (OUT_W - 1)) : '0;
  localparam logic [15:0] LAT16 = 16'(LATENCY);

  logic [3:0] ctrl_reg;
  logic clr_reg;
  logic stat_ovf_reg;
  logic [31:0] count_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [`FPR_ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_ready_reg;
  logic w_ready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic ar_ready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [15:0] en_run_reg;
  logic [OUT_W-1:0] pipe_data [LATENCY];
  logic pipe_valid [LATENCY];
  logic pipe_ovf [LATENCY];
  logic en;
  logic step;
  logic round_sel;
  logic sat_sel;
  logic do_write;
  logic ovf_evt;
  logic [OUT_W-1:0] res_data;
  logic res_ovf;
  logic [WW-1:0] q_trunc;
  logic [WW-1:0] q_full;
  logic [31:0] rd_mux;
  logic rd_hit;
  fpr_pkg::fpr_ovf_type ovf_mode;

  //////////////////////////////////////////////////////////////////////////////
  // Build-time format checks: full precision must really hold the exact value.
  if (LATENCY < 1) begin : g_bad_lat
    $error("Latency must be at least one register.");
  end
  if (FULL_PREC != 0 && (OUT_FRAC < IN_FRAC || OUT_W - OUT_FRAC < IN_W - IN_FRAC
      + ((IN_SIGNED == 0 && OUT_SIGNED != 0) ? 1 : 0) || (IN_SIGNED != 0 && OUT_SIGNED == 0)))
      begin : g_bad_full
    $error("Full-precision format cannot hold the exact result."); // RULE4
  end

  assign ovf_mode = fpr_pkg::fpr_ovf_type'(ctrl_reg[`FPR_CTRL_OVF_MSB:`FPR_CTRL_OVF_LSB]);
  assign en = ctrl_reg[`FPR_CTRL_EN_BIT];
  assign step = en && !clr_reg;
  // Modes are forced off in full precision; flag mode is plain wrap in hardware.
  assign round_sel = (FULL_PREC == 0) && ctrl_reg[`FPR_CTRL_RND_BIT]; // RULE5 RULE4
  assign sat_sel = (FULL_PREC == 0) && (ovf_mode == fpr_pkg::FPR_OVF_SAT); // RULE5 RULE8

  fpr_requant #(
    .IN_W(IN_W),
    .IN_FRAC(IN_FRAC),
    .IN_SIGNED(IN_SIGNED),
    .OUT_W(OUT_W),
    .OUT_FRAC(OUT_FRAC),
    .OUT_SIGNED(OUT_SIGNED) // RULE1
  ) u_requant (
    .din(in_data),
    .round_sel(round_sel),
    .sat_sel(sat_sel),
    .dout(res_data),
    .ovf(res_ovf),
    .q_trunc(q_trunc),
    .q_full(q_full)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Output delay line; clear wins over enable, enable low freezes every stage.
  for (genvar i = 0; i < LATENCY; i++) begin : g_stage
    logic [OUT_W-1:0] d_in;
    logic v_in;
    logic o_in;
    if (i == 0) begin : g_head
      assign d_in = res_data;
      assign v_in = in_valid;
      assign o_in = res_ovf && in_valid;
    end else begin : g_link
      assign d_in = pipe_data[i-1];
      assign v_in = pipe_valid[i-1];
      assign o_in = pipe_ovf[i-1];
    end
    always_ff @(posedge aclk) begin
      if (!aresetn || clr_reg) begin
        pipe_data[i] <= '0; // RULE12
        pipe_valid[i] <= 1'b0;
        pipe_ovf[i] <= 1'b0;
      end else if (en) begin
        pipe_data[i] <= d_in; // RULE11
        pipe_valid[i] <= v_in;
        pipe_ovf[i] <= o_in;
      end
    end
  end

  assign out_data = pipe_data[LATENCY-1];
  assign out_valid = pipe_valid[LATENCY-1];
  assign out_ovf = pipe_ovf[LATENCY-1];

  //////////////////////////////////////////////////////////////////////////////
  // Status: sticky overflow flag and accepted-sample counter.
  assign ovf_evt = step && in_valid && res_ovf;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ovf_reg <= 1'b0;
    end else if (ovf_evt) begin
      stat_ovf_reg <= 1'b1;
    end else if (do_write && awaddr_reg == `FPR_STATUS_OFS && wstrb_reg[0]
        && wdata_reg[`FPR_STAT_OVF_BIT]) begin
      stat_ovf_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clr_reg) begin
      count_reg <= '0;
    end else if (step && in_valid) begin
      count_reg <= count_reg + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register; the clear bit is a one-cycle pulse and is not stored.
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `FPR_CTRL_RST;
      clr_reg <= 1'b0;
    end else if (do_write && awaddr_reg == `FPR_CTRL_OFS && wstrb_reg[0]) begin
      ctrl_reg <= wdata_reg[`FPR_CTRL_OVF_MSB:`FPR_CTRL_EN_BIT];
      clr_reg <= wdata_reg[`FPR_CTRL_CLR_BIT];
    end else begin
      clr_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write channels are taken independently; the response follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ready_reg <= 1'b1;
      aw_full_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid && aw_ready_reg) begin
      aw_ready_reg <= 1'b0;
      aw_full_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full_reg <= 1'b0;
    end else if (bvalid_reg && s_axi_bready) begin
      aw_ready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_ready_reg <= 1'b1;
      w_full_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (s_axi_wvalid && w_ready_reg) begin
      w_ready_reg <= 1'b0;
      w_full_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_full_reg <= 1'b0;
    end else if (bvalid_reg && s_axi_bready) begin
      w_ready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `FPR_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (awaddr_reg > `FPR_CONFIG_OFS || awaddr_reg[1:0] != 2'h0)
          ? `FPR_RESP_SLVERR : `FPR_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path: one outstanding read, data registered with the address.
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `FPR_CTRL_OFS: rd_mux[`FPR_CTRL_OVF_MSB:`FPR_CTRL_EN_BIT] = ctrl_reg;
      `FPR_STATUS_OFS: rd_mux[`FPR_STAT_OVF_BIT] = stat_ovf_reg;
      `FPR_RESULT_OFS: rd_mux = 32'(pipe_data[LATENCY-1][RW-1:0]);
      `FPR_COUNT_OFS: rd_mux = count_reg;
      `FPR_CONFIG_OFS: begin
        rd_mux[`FPR_CFG_W_MSB:0] = 16'(OUT_W);
        rd_mux[`FPR_CFG_FRAC_MSB:`FPR_CFG_FRAC_LSB] = 13'(OUT_FRAC);
        rd_mux[`FPR_CFG_FULL_BIT] = (FULL_PREC != 0);
        rd_mux[`FPR_CFG_SIGN_BIT] = (OUT_SIGNED != 0);
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_ready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= `FPR_RESP_OKAY;
      rdata_reg <= '0;
    end else if (s_axi_arvalid && ar_ready_reg) begin
      ar_ready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_hit ? `FPR_RESP_OKAY : `FPR_RESP_SLVERR;
      rdata_reg <= rd_mux;
    end else if (rvalid_reg && s_axi_rready) begin
      ar_ready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready = aw_ready_reg;
  assign s_axi_wready = w_ready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ar_ready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks. The run counter tells how many edges in a row the line has advanced.
  always_ff @(posedge aclk) begin
    if (!aresetn || !step) begin
      en_run_reg <= '0;
    end else if (en_run_reg != 16'hffff) begin
      en_run_reg <= en_run_reg + 16'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_sat_high_clamp: assert property (sat_sel && res_ovf && !q_full[WW-1] // RULE6
      |-> res_data == SAT_HI) else $error("Saturation high code wrong.");
  chk_sat_low_clamp: assert property (sat_sel && res_ovf && q_full[WW-1] // RULE6
      |-> res_data == SAT_LO) else $error("Saturation low code wrong.");
  chk_wrap_low_bits: assert property (!sat_sel // RULE7
      |-> res_data == q_full[OUT_W-1:0]) else $error("Wrap result wrong.");
  chk_trunc_no_incr: assert property (!round_sel // RULE10
      |-> q_full == q_trunc) else $error("Truncate added an increment.");
  chk_round_step_one: assert property (round_sel // RULE9
      |-> q_full == q_trunc || q_full == q_trunc + WW'(1)) else $error("Round step too big.");
  chk_full_prec_exact: assert property ((FULL_PREC != 0) // RULE4
      |-> !res_ovf && q_full == q_trunc) else $error("Full precision result altered.");
  chk_latency_data: assert property (en_run_reg >= LAT16 // RULE11
      |-> out_data == $past(res_data, LATENCY) && out_valid == $past(in_valid, LATENCY))
      else $error("Delay line latency wrong.");
  chk_hold_disabled: assert property (!en && !clr_reg // RULE13
      |=> $stable(out_data) && $stable(out_valid)) else $error("Output moved while disabled.");
  chk_clear_wins: assert property (clr_reg && en // RULE12
      |=> !out_valid && out_data == '0 && count_reg == '0) else $error("Clear did not win.");
  chk_sticky_set_wins: assert property (ovf_evt // RULE6
      |=> stat_ovf_reg [*2] or (stat_ovf_reg ##1 !stat_ovf_reg)) else $error("Overflow lost.");

  cov_saturate: cover property (sat_sel && res_ovf && in_valid && step);
  cov_round_up: cover property (round_sel && q_full != q_trunc && in_valid);
  cov_wrap_ovf: cover property (!sat_sel && res_ovf && in_valid);
  cov_write_done: cover property (bvalid_reg && s_axi_bready ##1 s_axi_awready);

endmodule : fpr_top
